// *** core/scips_pkg.sv ***
// Constants, register map and carrier types of the interrupt and power supervisor
`default_nettype none
package scips_pkg;

    // Register offsets, status and settings one per card slot (slot 0 is the user card)
    localparam logic [3:0][7:0] ADDR_SLOT_STAT  = {8'h30, 8'h20, 8'h10, 8'h00};
    localparam logic [3:0][7:0] ADDR_SLOT_SET   = {8'h31, 8'h21, 8'h11, 8'h01};
    localparam logic [7:0]      ADDR_IRQ_STAT   = 8'h41;
    localparam logic [7:0]      ADDR_PWR_CTRL   = 8'h42;

    // Slot status register fields
    localparam int ST_ACTIVE  = 7;
    localparam int ST_EARLY   = 6;
    localparam int ST_LATE    = 5;
    localparam int ST_OC      = 4;
    localparam int ST_PRESL   = 2;
    localparam int ST_PRES    = 1;
    localparam int ST_OTEMP   = 2;
    localparam int ST_UVOLT   = 1;
    localparam int ST_RAMP    = 0;

    // Interrupt status register fields
    localparam logic [3:0][2:0] IRQ_SLOT_BIT = {3'h6, 3'h5, 3'h4, 3'h7};
    localparam int IRQ_OTEMP  = 3;
    localparam int IRQ_UVOLT  = 2;
    localparam int IRQ_SYNC   = 1;
    localparam int IRQ_GPIO   = 0;

    // Power control and settings fields
    localparam int         PWR_BOOST_DIS = 7;
    localparam int         SET_VSEL_HI   = 7;
    localparam int         SET_VSEL_LO   = 6;
    localparam logic [1:0] VSEL_5V       = 2'h2;

    // Reset values and the data read at unmapped addresses
    localparam logic [7:0] UC_SET_RST    = 8'h60;
    localparam logic [7:0] SAM_SET_RST   = 8'h40;
    localparam logic [7:0] PWR_CTRL_RST  = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'hff;

    // Timing
    localparam int CLK_KHZ          = 10000;
    localparam int RAMP_TIMEOUT_US  = 5000;
    localparam int POWERUP_US       = 100;
    localparam int RAMP_CYCLES      = (RAMP_TIMEOUT_US * CLK_KHZ) / 1000;
    localparam int POWERUP_CYCLES   = (POWERUP_US * CLK_KHZ) / 1000;

    // Inputs arriving from outside the clock domain
    typedef struct packed {
        logic       pres;
        logic [3:0] oc;
        logic       vdd_low;
        logic       vddi_low;
        logic       otemp;
        logic       shdn_n;
        logic [3:0] gpio;
    } scips_async_type;

    typedef enum logic [1:0] {
        PS_OFF     = 2'b00,
        PS_POWERUP = 2'b01,
        PS_RUN     = 2'b10
    } scips_pwr_state_type;

endpackage
`default_nettype wire

// *** core/scips_top.sv ***
// Interrupt aggregation, fault flags, supply supervision and boost control
// Contract
// - Open-drain active-low request, low when pending
// - Card insertion/removal sets user irq and latch
// - Interrupt read clears flags; latch needs status read
// - Overcurrent sets slot flag and slot interrupt
// - Slot fault flags clear on status read or power off
// - Core undervoltage sets irq flag and status
// - Undervoltage and overtemp status follow condition
// - Overtemperature sets irq flag and status
// - Early answer-to-reset sets slot flag, interrupt
// - Late answer-to-reset sets slot flag, interrupt
// - Sync activation done sets flag, read clears
// - Supply ramp timeout sets ramp fault, interrupt
// - Input pin change sets pin-change irq flag
// - After power-up request asserted with no flag
// - Nothing works before power-on interrupt
// - Core undervoltage deactivates every card slot
// - IO supply loss: deactivate, power off, no fault
// - Boost disabled while disable bit set
// - Boost off in standby, on at activation
// - Boost target high when any 5 V card
// - No boost, low supply gives ramp fault
`timescale 1ns/1ps
`default_nettype none
module scips_top
    import scips_pkg::*;
#(
    parameter int RAMP_CYC    = RAMP_CYCLES,
    parameter int POWERUP_CYC = POWERUP_CYCLES
) (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_b_in,
    input  wire logic       card_present_in,
    input  wire logic [3:0] vcc_overcurrent_in,
    input  wire logic       core_supply_low_in,
    input  wire logic       io_supply_low_in,
    input  wire logic       overtemp_in,
    input  wire logic       shutdown_b_in,
    input  wire logic [3:0] gpio_level_in,
    input  wire logic [3:0] gpio_is_input_in,
    input  wire logic [3:0] async_mode_in,
    input  wire logic [3:0] atr_too_soon_in,
    input  wire logic [3:0] atr_too_late_in,
    input  wire logic       sync_activation_done_in,
    input  wire logic [3:0] activation_cmd_in,
    input  wire logic [3:0] deactivation_cmd_in,
    input  wire logic [3:0] vcc_ready_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_rd_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_wdata_in,
    output var  logic [7:0] reg_rdata_out,
    output var  logic       irq_o_out,
    output var  logic       irq_oe_out,
    output var  logic [3:0] slot_active_out,
    output var  logic [3:0] slot_deactivate_out,
    output var  logic       power_off_out,
    output var  logic       functions_ready_out,
    output var  logic       boost_enable_out,
    output var  logic       boost_target_high_out
);

    localparam int RW = $clog2(RAMP_CYC + 1);
    localparam int PW = $clog2(POWERUP_CYC + 1);
    localparam logic [RW-1:0] RAMP_LAST = RW'(RAMP_CYC - 1);
    localparam logic [PW-1:0] PUP_LAST  = PW'(POWERUP_CYC - 1);

    if (RAMP_CYC < 2 || POWERUP_CYC < 2) begin : g_bad_param
        $error("scips_top: timing counts must be at least 2");
    end

    // Three-stage synchroniser; a change is accepted once stages two and
    // three agree, so a single-cycle glitch on a pin never makes an event.
    scips_async_type sync_a_q, sync_a_d;
    scips_async_type sync_b_q, sync_b_d;
    scips_async_type sync_c_q, sync_c_d;
    scips_async_type filt_q,   filt_d;

    always_comb begin
        logic [12:0] agree;
        agree    = ~(sync_b_q ^ sync_c_q);
        sync_a_d = {card_present_in, vcc_overcurrent_in, core_supply_low_in,
                    io_supply_low_in, overtemp_in, shutdown_b_in,
                    gpio_level_in};
        sync_b_d = sync_a_q;
        sync_c_d = sync_b_q;
        filt_d   = (sync_c_q & agree) | (filt_q & ~agree);
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync_a_q <= '0;
            sync_b_q <= '0;
            sync_c_q <= '0;
            filt_q   <= '0;
        end else begin
            sync_a_q <= sync_a_d;
            sync_b_q <= sync_b_d;
            sync_c_q <= sync_c_d;
            filt_q   <= filt_d;
        end
    end

    // Main state
    scips_pwr_state_type   state_q,   state_d;
    logic [PW-1:0]         pup_cnt_q, pup_cnt_d;
    logic                  por_q,     por_d;
    logic [7:0]            irq_q,     irq_d;
    logic [3:0]            early_q,   early_d;
    logic [3:0]            late_q,    late_d;
    logic [3:0]            oc_q,      oc_d;
    logic [3:0]            ramp_q,    ramp_d;
    logic                  presl_q,   presl_d;
    logic [3:0]            active_q,  active_d;
    logic [3:0]            ramping_q, ramping_d;
    logic [3:0][RW-1:0]    rcnt_q,    rcnt_d;
    logic [3:0][1:0]       vsel_q,    vsel_d;
    logic [3:0][7:0]       set_q,     set_d;
    logic [7:0]            pwr_q,     pwr_d;
    logic [7:0]            rdata_q,   rdata_d;
    logic                  irq_oe_q,  irq_oe_d;
    logic [3:0]            deact_q,   deact_d;
    logic                  poff_q,    poff_d;
    logic                  ready_q,   ready_d;
    logic                  boost_q,   boost_d;
    logic                  bhigh_q,   bhigh_d;

    always_comb begin
        logic       ready;
        logic       kill_all;
        logic       irq_clr;
        logic [7:0] irq_set;
        logic [7:0] mux;
        logic [7:0] st;
        logic       stat_clr;
        logic       act_start;
        logic       kill;
        logic       timeout;
        logic       oc_set;
        logic       early_set;
        logic       late_set;
        logic       pres_chg;
        logic       five_v;
        ready     = (state_q == PS_RUN);
        kill_all  = !ready || filt_q.vdd_low;
        irq_clr   = reg_rd_in && (reg_addr_in == ADDR_IRQ_STAT);
        irq_set   = '0;
        mux       = UNMAPPED_DATA;
        st        = '0;
        stat_clr  = 1'b0;
        act_start = 1'b0;
        kill      = 1'b0;
        timeout   = 1'b0;
        oc_set    = 1'b0;
        early_set = 1'b0;
        late_set  = 1'b0;
        pres_chg  = 1'b0;
        five_v    = 1'b0;
        state_d   = state_q;
        pup_cnt_d = pup_cnt_q;
        por_d     = por_q && !irq_clr;
        early_d   = early_q;
        late_d    = late_q;
        oc_d      = oc_q;
        ramp_d    = ramp_q;
        presl_d   = presl_q;
        active_d  = active_q;
        ramping_d = ramping_q;
        rcnt_d    = rcnt_q;
        vsel_d    = vsel_q;
        set_d     = set_q;
        pwr_d     = pwr_q;
        deact_d   = '0;

        // Power sequencing; IO supply loss forces power off silently
        unique case (state_q)
            PS_OFF: begin
                pup_cnt_d = '0;
                if (filt_q.shdn_n && !filt_q.vddi_low) begin
                    state_d = PS_POWERUP;
                end
            end
            PS_POWERUP: begin
                pup_cnt_d = pup_cnt_q + PW'(1);
                if (pup_cnt_q == PUP_LAST) begin
                    state_d = PS_RUN;
                    por_d   = 1'b1;
                end
            end
            PS_RUN: begin
                pup_cnt_d = '0;
            end
            default: begin
                state_d = PS_OFF;
            end
        endcase
        if (!filt_q.shdn_n || filt_q.vddi_low) begin
            state_d = PS_OFF;
            por_d   = 1'b0;
        end

        // Global events, taken only while running
        if (ready) begin
            irq_set[IRQ_UVOLT] = filt_d.vdd_low && !filt_q.vdd_low;
            irq_set[IRQ_OTEMP] = filt_d.otemp && !filt_q.otemp;
            irq_set[IRQ_SYNC]  = sync_activation_done_in;
            irq_set[IRQ_GPIO]  = |((filt_d.gpio ^ filt_q.gpio)
                                   & gpio_is_input_in);
        end

        for (int i = 0; i < 4; i++) begin
            stat_clr  = reg_rd_in && (reg_addr_in == ADDR_SLOT_STAT[i]);
            act_start = ready && activation_cmd_in[i] && !active_q[i];
            timeout   = ramping_q[i] && !vcc_ready_in[i]
                        && (rcnt_q[i] == RAMP_LAST);
            oc_set    = ready && filt_d.oc[i] && !filt_q.oc[i];
            early_set = ready && async_mode_in[i] && atr_too_soon_in[i];
            late_set  = ready && async_mode_in[i] && atr_too_late_in[i];
            pres_chg  = ready && (i == 0)
                        && (filt_d.pres != filt_q.pres);
            kill      = kill_all || deactivation_cmd_in[i]
                        || filt_q.oc[i] || timeout;

            // Supply ramp watchdog; without boost a low supply lands here
            if (act_start) begin
                ramping_d[i] = 1'b1;
                rcnt_d[i]    = '0;
                vsel_d[i]    = set_q[i][SET_VSEL_HI:SET_VSEL_LO];
            end else if (vcc_ready_in[i] || kill) begin
                ramping_d[i] = 1'b0;
            end else if (ramping_q[i]) begin
                rcnt_d[i] = rcnt_q[i] + RW'(1);
            end
            active_d[i] = (active_q[i] || act_start) && !kill;
            deact_d[i]  = active_q[i] && kill;

            // Latched slot faults: set wins over the read clear
            oc_d[i]    = (oc_q[i] && !stat_clr) || oc_set;
            early_d[i] = (early_q[i] && !stat_clr) || early_set;
            late_d[i]  = (late_q[i] && !stat_clr) || late_set;
            ramp_d[i]  = (ramp_q[i] && !stat_clr) || timeout;
            if (i == 0) begin
                presl_d = (presl_q && !stat_clr) || pres_chg;
            end
            irq_set[IRQ_SLOT_BIT[i]] = oc_set || early_set || late_set
                                       || timeout || pres_chg;

            five_v = five_v || (active_d[i] && (vsel_d[i] == VSEL_5V));

            // Settings writes ignored until the device is up
            if (ready && reg_wr_in && (reg_addr_in == ADDR_SLOT_SET[i])) begin
                set_d[i] = reg_wdata_in;
            end

            st            = '0;
            st[ST_ACTIVE] = active_q[i];
            st[ST_EARLY]  = early_q[i];
            st[ST_LATE]   = late_q[i];
            st[ST_OC]     = oc_q[i];
            st[ST_RAMP]   = ramp_q[i];
            if (i == 0) begin
                st[ST_PRESL] = presl_q;
                st[ST_PRES]  = filt_q.pres;
            end
            if (i == 1) begin
                st[ST_OTEMP] = filt_q.otemp;
                st[ST_UVOLT] = filt_q.vdd_low;
            end
            if (reg_addr_in == ADDR_SLOT_STAT[i]) begin
                mux = st;
            end
            if (reg_addr_in == ADDR_SLOT_SET[i]) begin
                mux = set_q[i];
            end
        end

        if (ready && reg_wr_in && (reg_addr_in == ADDR_PWR_CTRL)) begin
            pwr_d = reg_wdata_in;
        end
        if (reg_addr_in == ADDR_IRQ_STAT) begin
            mux = irq_q;
        end
        if (reg_addr_in == ADDR_PWR_CTRL) begin
            mux = pwr_q;
        end

        irq_d = (irq_q & ~{8{irq_clr}}) | irq_set;
        if (state_d == PS_OFF) begin
            irq_d    = '0;
            early_d  = '0;
            late_d   = '0;
            oc_d     = '0;
            ramp_d   = '0;
            presl_d  = 1'b0;
        end
        rdata_d  = reg_rd_in ? mux : rdata_q;
        irq_oe_d = (|irq_d) || por_d;
        poff_d   = (state_d == PS_OFF);
        ready_d  = (state_d == PS_RUN);
        // Boost runs only with a card active; target follows any 5 V slot
        boost_d  = ready && !pwr_q[PWR_BOOST_DIS]
                   && (|active_d);
        bhigh_d  = boost_d && five_v;
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q   <= PS_OFF;
            pup_cnt_q <= '0;
            por_q     <= 1'b0;
            irq_q     <= '0;
            early_q   <= '0;
            late_q    <= '0;
            oc_q      <= '0;
            ramp_q    <= '0;
            presl_q   <= 1'b0;
            active_q  <= '0;
            ramping_q <= '0;
            rcnt_q    <= '0;
            vsel_q    <= '0;
            set_q     <= {SAM_SET_RST, SAM_SET_RST, SAM_SET_RST, UC_SET_RST};
            pwr_q     <= PWR_CTRL_RST;
            rdata_q   <= '0;
            irq_oe_q  <= 1'b0;
            deact_q   <= '0;
            poff_q    <= 1'b1;
            ready_q   <= 1'b0;
            boost_q   <= 1'b0;
            bhigh_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            pup_cnt_q <= pup_cnt_d;
            por_q     <= por_d;
            irq_q     <= irq_d;
            early_q   <= early_d;
            late_q    <= late_d;
            oc_q      <= oc_d;
            ramp_q    <= ramp_d;
            presl_q   <= presl_d;
            active_q  <= active_d;
            ramping_q <= ramping_d;
            rcnt_q    <= rcnt_d;
            vsel_q    <= vsel_d;
            set_q     <= set_d;
            pwr_q     <= pwr_d;
            rdata_q   <= rdata_d;
            irq_oe_q  <= irq_oe_d;
            deact_q   <= deact_d;
            poff_q    <= poff_d;
            ready_q   <= ready_d;
            boost_q   <= boost_d;
            bhigh_q   <= bhigh_d;
        end
    end

    // The pad only ever pulls low; the enable carries the request
    logic irq_pad_q;
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_pad_q <= 1'b0;
        end else begin
            irq_pad_q <= 1'b0;
        end
    end

    assign reg_rdata_out         = rdata_q;
    assign irq_o_out             = irq_pad_q;
    assign irq_oe_out            = irq_oe_q;
    assign slot_active_out       = active_q;
    assign slot_deactivate_out   = deact_q;
    assign power_off_out         = poff_q;
    assign functions_ready_out   = ready_q;
    assign boost_enable_out      = boost_q;
    assign boost_target_high_out = bhigh_q;

endmodule
`default_nettype wire

// *** sim/scips_monitor.sv ***
// Port-level checks for the interrupt and power supervisor
`timescale 1ns/1ps
`default_nettype none
module scips_monitor
    import scips_pkg::*;
(
    input wire logic       clk_sys_in,
    input wire logic       rst_b_in,
    input wire logic [3:0] vcc_overcurrent_in,
    input wire logic       core_supply_low_in,
    input wire logic [3:0] async_mode_in,
    input wire logic [3:0] atr_too_soon_in,
    input wire logic [3:0] atr_too_late_in,
    input wire logic       sync_activation_done_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       irq_o_out,
    input wire logic       irq_oe_out,
    input wire logic [3:0] slot_active_out,
    input wire logic       power_off_out,
    input wire logic       functions_ready_out,
    input wire logic       boost_enable_out
);
    logic boost_off_q;
    logic boost_off_d;

    // Disable-bit shadow; power off drops it to avoid false alarms
    always_comb begin
        boost_off_d = boost_off_q;
        if (power_off_out) begin
            boost_off_d = 1'b0;
        end else if (reg_wr_in && functions_ready_out
                     && reg_addr_in == ADDR_PWR_CTRL) begin
            boost_off_d = reg_wdata_in[PWR_BOOST_DIS];
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            boost_off_q <= 1'b0;
        end else begin
            boost_off_q <= boost_off_d;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_uv_held;
        core_supply_low_in [*8];
    endsequence
    sequence s_off_held;
        power_off_out [*2];
    endsequence

    a_irq_open_drain: assert property (!irq_o_out)
        else $error("request line driven high");
    a_por_irq_up: assert property (
        $rose(functions_ready_out) |-> irq_oe_out)
        else $error("no power-on request");
    a_no_func_early: assert property (
        !functions_ready_out && !$past(functions_ready_out)
        |-> !irq_oe_out && !boost_enable_out && slot_active_out == 4'h0)
        else $error("activity before power-on");
    a_sync_done_irq: assert property (
        functions_ready_out && sync_activation_done_in
        |-> ##[1:2] irq_oe_out)
        else $error("sync done not flagged");
    a_early_atr_irq: assert property (
        functions_ready_out && |(atr_too_soon_in & async_mode_in)
        |-> ##[1:2] irq_oe_out)
        else $error("early answer not flagged");
    a_late_atr_irq: assert property (
        functions_ready_out && |(atr_too_late_in & async_mode_in)
        |-> ##[1:2] irq_oe_out)
        else $error("late answer not flagged");
    a_oc_irq_raise: assert property (
        functions_ready_out && $rose(|vcc_overcurrent_in)
        |-> ##[3:10] irq_oe_out)
        else $error("overcurrent not flagged");
    a_uv_deact_all: assert property (
        s_uv_held |=> slot_active_out == 4'h0)
        else $error("slot active in undervoltage");
    a_off_deact_all: assert property (
        s_off_held |-> slot_active_out == 4'h0 && !functions_ready_out)
        else $error("slot active in power off");
    a_boost_held_off: assert property (
        boost_off_q && $past(boost_off_q) |-> !boost_enable_out)
        else $error("boost on while disabled");
endmodule
`default_nettype wire

// *** sim/scips_host_model.sv ***
// Host side: register master and the pulled-up request wire
`timescale 1ns/1ps
`default_nettype none
module scips_host_model (
    input  wire logic       clk_sys_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       irq_o_in,
    input  wire logic       irq_oe_in,
    output var  logic [7:0] addr_out,
    output var  logic       rd_out,
    output var  logic       wr_out,
    output var  logic [7:0] wdata_out,
    output var  logic       irq_line_b_out
);
    // The pull-up wins when nobody pulls low
    assign irq_line_b_out = irq_oe_in ? irq_o_in : 1'b1;

    initial begin
        addr_out = 8'h00;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 8'h00;
    end

    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [7:0] wd, output logic [7:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        wdata_out <= wd;
        rd_out <= !w;
        wr_out <= w;
        @(posedge clk_sys_in);
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        // Released bus shows the inverse
        addr_out <= ~a;
        wdata_out <= ~wd;
        #1;
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

// *** sim/scips_top_tb.sv ***
// Self-checking bench for the interrupt and power supervisor
`timescale 1ns/1ps
`default_nettype none
module scips_top_tb
    import scips_pkg::*;
;
    logic       clk_sys_in = 1'b0, rst_b_in = 1'b0;
    logic       card_present_in = 1'b0, core_supply_low_in = 1'b0;
    logic       io_supply_low_in = 1'b0, overtemp_in = 1'b0;
    logic       shutdown_b_in = 1'b1, sync_activation_done_in = 1'b0;
    logic [3:0] vcc_overcurrent_in = 4'h0, gpio_level_in = 4'h0;
    logic [3:0] gpio_is_input_in = 4'h5, async_mode_in = 4'hf;
    logic [3:0] atr_too_soon_in = 4'h0, atr_too_late_in = 4'h0;
    logic [3:0] activation_cmd_in = 4'h0, deactivation_cmd_in = 4'h0;
    logic [3:0] vcc_ready_in = 4'hf, slot_active_out, slot_deactivate_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, n_d = 8'h00;
    logic       reg_rd_in, reg_wr_in, irq_o_out, irq_oe_out, irq_line_b;
    logic       power_off_out, functions_ready_out, boost_enable_out;
    logic       boost_target_high_out;
    int         n_mismatch = 0, comparisons = 0, cyc = 0, seed = 33, g;
    int         m_irq = 0;
    int         m_st[4] = '{default: 0};

    scips_top #(.RAMP_CYC(20), .POWERUP_CYC(4)) scips_top_i (.*);
    scips_host_model scips_host_model_i (
        .clk_sys_in(clk_sys_in), .rdata_in(reg_rdata_out),
        .irq_o_in(irq_o_out), .irq_oe_in(irq_oe_out),
        .addr_out(reg_addr_in), .rd_out(reg_rd_in), .wr_out(reg_wr_in),
        .wdata_out(reg_wdata_in), .irq_line_b_out(irq_line_b));

    initial begin
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cyc++;
        n_d += 8'(|slot_deactivate_out);
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        scips_host_model_i.xfer(a, 1'b0, 8'h00, d);
        cmp(d, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] d;
        scips_host_model_i.xfer(a, 1'b1, v, d);
    endtask
    // Model: a read clears what it reports
    task automatic rd_irq();
        chk(ADDR_IRQ_STAT, 8'(m_irq));
        cmp(irq_line_b, 1'b1);
        m_irq = 0;
    endtask
    task automatic rd_st(input int s, input logic [7:0] live);
        chk(ADDR_SLOT_STAT[s], 8'(m_st[s]) | live);
        m_st[s] = 0;
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_line_b !== 1'b0 && n < 80) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        repeat (2) @(posedge clk_sys_in);
        #1;
        cmp(irq_line_b, 1'b0);
    endtask
    task automatic power_up();
        int n;
        n = 0;
        while (functions_ready_out !== 1'b1 && n < 100) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        cmp(irq_line_b, 1'b0);
        rd_irq();
    endtask
    task automatic strobe(input logic [3:0] act, input logic [3:0] deact,
                          input logic [3:0] soon, input logic [3:0] late,
                          input logic sync);
        @(posedge clk_sys_in);
        activation_cmd_in <= act;
        deactivation_cmd_in <= deact;
        atr_too_soon_in <= soon;
        atr_too_late_in <= late;
        sync_activation_done_in <= sync;
        @(posedge clk_sys_in);
        activation_cmd_in <= 4'h0;
        deactivation_cmd_in <= 4'h0;
        atr_too_soon_in <= 4'h0;
        atr_too_late_in <= 4'h0;
        sync_activation_done_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        wr(ADDR_PWR_CTRL, 8'h80);
        power_up();
        chk(ADDR_PWR_CTRL, PWR_CTRL_RST);
        chk(ADDR_SLOT_SET[0], UC_SET_RST);
        for (int s = 1; s < 4; s++) begin
            chk(ADDR_SLOT_SET[s], SAM_SET_RST);
        end
        chk(8'h55, UNMAPPED_DATA);
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk_sys_in);
            card_present_in <= v[0];
            m_irq |= 1 << IRQ_SLOT_BIT[0];
            m_st[0] |= 1 << ST_PRESL;
            wait_irq();
            rd_irq();
            rd_st(0, 8'(v << ST_PRES));
            rd_st(0, 8'(v << ST_PRES));
        end
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_sys_in);
            vcc_overcurrent_in <= 4'h1 << s;
            m_irq |= 1 << IRQ_SLOT_BIT[s];
            m_st[s] |= 1 << ST_OC;
            wait_irq();
            rd_irq();
            @(posedge clk_sys_in);
            vcc_overcurrent_in <= 4'h0;
            rd_st(s, 8'h00);
            rd_st(s, 8'h00);
        end
        for (int s = 0; s < 4; s++) begin
            strobe(4'h0, 4'h0, 4'h1 << s, 4'h1 << s, 1'b0);
            m_irq |= 1 << IRQ_SLOT_BIT[s];
            m_st[s] |= (1 << ST_EARLY) | (1 << ST_LATE);
            rd_irq();
            rd_st(s, 8'h00);
        end
        // Sync mode: answer timing ignored
        @(posedge clk_sys_in);
        async_mode_in <= 4'h0;
        strobe(4'h0, 4'h0, 4'hf, 4'hf, 1'b1);
        m_irq |= 1 << IRQ_SYNC;
        rd_irq();
        rd_irq();
        async_mode_in <= 4'hf;
        wr(ADDR_SLOT_SET[1], {VSEL_5V, 6'h00});
        strobe(4'h2, 4'h0, 4'h0, 4'h0, 1'b0);
        cmp(slot_active_out, 4'h2);
        cmp(boost_enable_out, 1'b1);
        cmp(boost_target_high_out, 1'b1);
        @(posedge clk_sys_in);
        core_supply_low_in <= 1'b1;
        overtemp_in <= 1'b1;
        m_irq |= (1 << IRQ_UVOLT) | (1 << IRQ_OTEMP);
        wait_irq();
        rd_irq();
        cmp(slot_active_out, 4'h0);
        rd_st(1, 8'h06);
        @(posedge clk_sys_in);
        core_supply_low_in <= 1'b0;
        overtemp_in <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        rd_st(1, 8'h00);
        wr(ADDR_PWR_CTRL, 8'h80);
        chk(ADDR_PWR_CTRL, 8'h80);
        vcc_ready_in <= 4'hb;
        strobe(4'h4, 4'h0, 4'h0, 4'h0, 1'b0);
        cmp(boost_enable_out, 1'b0);
        m_irq |= 1 << IRQ_SLOT_BIT[2];
        m_st[2] |= 1 << ST_RAMP;
        wait_irq();
        rd_irq();
        cmp(slot_active_out, 4'h0);
        rd_st(2, 8'h00);
        wr(ADDR_PWR_CTRL, 8'h00);
        vcc_ready_in <= 4'hf;
        strobe(4'h8, 4'h0, 4'h0, 4'h0, 1'b0);
        cmp(boost_enable_out, 1'b1);
        cmp(boost_target_high_out, 1'b0);
        strobe(4'h0, 4'h8, 4'h0, 4'h0, 1'b0);
        cmp(boost_enable_out, 1'b0);
        for (int k = 0; k < 8; k++) begin
            g = $random(seed);
            @(posedge clk_sys_in);
            if (((g[3:0] ^ gpio_level_in) & gpio_is_input_in) != 4'h0) begin
                m_irq |= 1 << IRQ_GPIO;
            end
            gpio_level_in <= g[3:0];
            repeat (12) @(posedge clk_sys_in);
            #1;
            cmp(irq_line_b, m_irq == 0);
            rd_irq();
        end
        strobe(4'h1, 4'h0, 4'h0, 4'h0, 1'b0);
        io_supply_low_in <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
        #1;
        cmp(power_off_out, 1'b1);
        cmp(slot_active_out, 4'h0);
        io_supply_low_in <= 1'b0;
        power_up();
        cmp(n_d, 8'h04);
        summarize();
    end
endmodule

bind scips_top scips_monitor scips_monitor_i (.*);
`default_nettype wire
